// ---- hdl/pmpcfg_pkg.sv ----
/*
  Constants for the pin configuration and core rail reset block.
  Assumes one 250 MHz clock and an active-low asynchronous reset.
*/
package pmpcfg_pkg;
  // ==========================================================
  // widths and reset values
  localparam int unsigned VSEL_W           = 6;
  localparam logic [5:0]  CORE_ONE_DEFAULT = 6'h00;
  localparam logic [5:0]  CORE_TWO_DEFAULT = 6'h00;
  localparam int unsigned SLEW_DIV_W       = 8;
  localparam logic [7:0]  SLEW_DIV_RESET   = 8'h10;
  localparam logic        LATCH_MODE_RESET = 1'b0;

  typedef enum logic [1:0] {
    PMPCFG_RAMP_IDLE,
    PMPCFG_RAMP_RUN
  } pmpcfg_ramp_e;
endpackage : pmpcfg_pkg

// ---- hdl/pmpcfg_top.sv ----
/*
  Three general-purpose pin configuration with core rail voltage restore.
    first pin  : open-drain output, or memory reset input from the host
    second pin : open-drain or push-pull output, from its user bit or,
                 in input mode, from the memory reset and power_good
    third pin  : open-drain output, or falling-edge restore input that
                 returns both core rail settings to their defaults
  The two core rails ramp one code per slew tick toward their targets.

  Assumes pin inputs are synchronous to i_sys_clk; the pad resolves
  output enables into the wire level, with pull-ups on the open-drain
  pins so a released pin reads high.
  Assumes the core rail writes are one-cycle strobes.
  Assumes one clock; the slew rate is a divided enable, not a clock.
*/
`timescale 1ns/100ps

// Behaviour
// - first pin open-drain output from user/sequencer
// - first pin level 0 low, 1 released
// - input mode takes memory reset, latch/pass
// - second pin is an output whatever the input select
// - second pin open-drain from user bit
// - second pin push-pull from user bit
// - input mode drives second from first, power_good
// - third pin open-drain output from user/sequencer
// - third pin falling edge restores core voltages
// - restored rails ramp at slew, stay on
module pmpcfg_top
  import pmpcfg_pkg::*;
#(
  parameter int unsigned W = pmpcfg_pkg::VSEL_W
) (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_first_pin_input_select,
  input  wire logic                           i_second_pin_pushpull_select,
  input  wire logic                           i_core_rail_reset_enable,
  input  wire logic                           i_memreset_latch_mode,
  input  wire logic                           i_first_pin_user_level,
  input  wire logic                           i_second_pin_user_level,
  input  wire logic                           i_third_pin_user_level,
  input  wire logic                           i_first_seq_ctrl,
  input  wire logic                           i_first_seq_level,
  input  wire logic                           i_third_seq_ctrl,
  input  wire logic                           i_third_seq_level,
  input  wire logic                           i_power_good,
  input  wire logic                           i_first_multi_pin_in,
  input  wire logic                           i_third_multi_pin_in,
  input  wire logic                           i_core_one_wr,
  input  wire logic [W-1:0]                   i_core_one_wdata,
  input  wire logic                           i_core_two_wr,
  input  wire logic [W-1:0]                   i_core_two_wdata,
  input  wire logic [pmpcfg_pkg::SLEW_DIV_W-1:0] i_slew_div,
  output logic                                o_first_multi_pin_out,
  output logic                                o_first_multi_pin_oe,
  output logic                                o_second_output_pin_out,
  output logic                                o_second_output_pin_oe,
  output logic                                o_third_multi_pin_out,
  output logic                                o_third_multi_pin_oe,
  output logic [W-1:0]                        o_core_buck_one_target,
  output logic [W-1:0]                        o_core_buck_two_target,
  output logic [W-1:0]                        o_core_buck_one_vsel,
  output logic [W-1:0]                        o_core_buck_two_vsel,
  output logic                                o_core_restore_pulse
);
  import pmpcfg_pkg::*;

  // ==========================================================
  // first pin
  logic first_level;

  // sequencer override takes the pin from the user bit
  always_comb begin
    if (i_first_seq_ctrl) begin
      first_level = i_first_seq_level;
    end else begin
      first_level = i_first_pin_user_level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_first_multi_pin_out <= 1'b0;
      o_first_multi_pin_oe  <= 1'b0;
    end else begin
      o_first_multi_pin_out <= 1'b0;
      // input mode releases the pad entirely
      o_first_multi_pin_oe  <= !i_first_pin_input_select && !first_level;
    end
  end

  // ==========================================================
  // memory reset capture from the first pin
  logic memrst_q;
  logic memrst_level;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      memrst_q <= 1'b1;
    end else if (!i_first_pin_input_select) begin
      memrst_q <= 1'b1;
    end else if (!i_memreset_latch_mode || !i_power_good) begin
      memrst_q <= i_first_multi_pin_in;
    end
  end
  // latch holds the value while power is good; pass mode follows the pin
  always_comb begin
    if (i_memreset_latch_mode) begin
      memrst_level = memrst_q;
    end else begin
      memrst_level = i_first_multi_pin_in;
    end
  end

  // ==========================================================
  // second pin
  logic second_level;
  always_comb begin
    if (i_first_pin_input_select) begin
      second_level = i_power_good && memrst_level;
    end else begin
      second_level = i_second_pin_user_level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_second_output_pin_out <= 1'b0;
      o_second_output_pin_oe  <= 1'b0;
    end else begin
      // always an output pin; input select only switches its level source
      o_second_output_pin_out <= i_second_pin_pushpull_select && second_level;
      o_second_output_pin_oe  <= i_second_pin_pushpull_select || !second_level;
    end
  end

  // ==========================================================
  // third pin
  logic third_level;

  always_comb begin
    if (i_third_seq_ctrl) begin
      third_level = i_third_seq_level;
    end else begin
      third_level = i_third_pin_user_level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_third_multi_pin_out <= 1'b0;
      o_third_multi_pin_oe  <= 1'b0;
    end else begin
      o_third_multi_pin_out <= 1'b0;
      o_third_multi_pin_oe  <= !i_core_rail_reset_enable && !third_level;
    end
  end

  // ==========================================================
  // third pin restore edge detector
  // two samples; an edge counts only once both hold real pin levels,
  // so a pin already low at reset release gives no false restore
  logic       third_s1_q;
  logic       third_s2_q;
  logic [1:0] third_primed_q;
  logic       restore;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      third_primed_q <= 2'h0;
    end else begin
      third_primed_q <= {third_primed_q[0], 1'b1};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      third_s1_q <= 1'b1;
      third_s2_q <= 1'b1;
    end else begin
      third_s1_q <= i_third_multi_pin_in;
      third_s2_q <= third_s1_q;
    end
  end

  always_comb begin
    restore = 1'b0;
    if (i_core_rail_reset_enable && third_primed_q[1]) begin
      restore = third_s2_q && !third_s1_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_core_restore_pulse <= 1'b0;
    end else begin
      o_core_restore_pulse <= restore;
    end
  end

  // ==========================================================
  // core voltage settings, one lane per rail
  // lane 0 is core_buck_one, lane 1 is core_buck_two
  localparam int unsigned             RAILS        = 2;
  localparam logic [RAILS-1:0][W-1:0] RAIL_DEFAULT = {W'(CORE_TWO_DEFAULT), W'(CORE_ONE_DEFAULT)};

  logic [RAILS-1:0]        rail_wr;
  logic [RAILS-1:0][W-1:0] rail_wdata;
  logic [W-1:0]            rail_target_q [RAILS];
  logic [W-1:0]            rail_vsel_q   [RAILS];

  assign rail_wr    = {i_core_two_wr, i_core_one_wr};
  assign rail_wdata = {i_core_two_wdata, i_core_one_wdata};

  for (genvar r = 0; r < RAILS; r++) begin : g_target
    // restore wins over a same-cycle write; other settings untouched
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        rail_target_q[r] <= RAIL_DEFAULT[r];
      end else if (restore) begin
        rail_target_q[r] <= RAIL_DEFAULT[r];
      end else if (rail_wr[r]) begin
        rail_target_q[r] <= rail_wdata[r];
      end
    end
  end

  assign o_core_buck_one_target = rail_target_q[0];
  assign o_core_buck_two_target = rail_target_q[1];

  // ==========================================================
  // slew: one code step per tick, rails never switched off
  logic [SLEW_DIV_W-1:0] slew_cnt_q;
  logic                  slew_tick;
  assign slew_tick = (slew_cnt_q == '0);
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slew_cnt_q <= SLEW_DIV_RESET;
    end else if (slew_tick) begin
      slew_cnt_q <= i_slew_div;
    end else begin
      slew_cnt_q <= slew_cnt_q - 1'b1;
    end
  end

  // ==========================================================
  // ramp: a restore only moves the target, so the rail walks back
  // at the slew rate instead of dropping out
  for (genvar r = 0; r < RAILS; r++) begin : g_ramp
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        rail_vsel_q[r] <= RAIL_DEFAULT[r];
      end else if (slew_tick) begin
        if (rail_vsel_q[r] < rail_target_q[r]) begin
          rail_vsel_q[r] <= rail_vsel_q[r] + 1'b1;
        end else if (rail_vsel_q[r] > rail_target_q[r]) begin
          rail_vsel_q[r] <= rail_vsel_q[r] - 1'b1;
        end
      end
    end
  end

  assign o_core_buck_one_vsel = rail_vsel_q[0];
  assign o_core_buck_two_vsel = rail_vsel_q[1];
endmodule : pmpcfg_top

// ---- tb/pmpcfg_properties.sv ----
/* Port assertions for pmpcfg_top.
   Assumes it is bound into pmpcfg_top and sees its ports only. */
`timescale 1ns/100ps
module pmpcfg_properties
  import pmpcfg_pkg::*;
#(parameter int unsigned W = VSEL_W) (
  input wire logic i_sys_clk, i_reset_n, i_first_pin_input_select, i_first_seq_ctrl,
  input wire logic i_second_pin_pushpull_select, i_second_pin_user_level, i_power_good,
  input wire logic i_core_rail_reset_enable, i_third_seq_ctrl, i_third_multi_pin_in,
  input wire logic i_first_pin_user_level, i_third_pin_user_level, o_core_restore_pulse,
  input wire logic o_first_multi_pin_oe, o_first_multi_pin_out, o_third_multi_pin_oe,
  input wire logic o_second_output_pin_oe, o_second_output_pin_out, o_third_multi_pin_out,
  input wire logic [W-1:0] o_core_buck_one_target, o_core_buck_two_target, o_core_buck_one_vsel
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========
  // restore path: pin seen high then low with the feature on
  sequence third_fall_s;
    i_core_rail_reset_enable && i_third_multi_pin_in
      ##1 i_core_rail_reset_enable && !i_third_multi_pin_in;
  endsequence
  first_od_a:
    assert property (!i_first_pin_input_select && !i_first_seq_ctrl |=> !o_first_multi_pin_out
      && o_first_multi_pin_oe == !$past(i_first_pin_user_level)) else $error("first pin");
  second_od_a:
    assert property (!i_first_pin_input_select && !i_second_pin_pushpull_select |=>
      !o_second_output_pin_out && o_second_output_pin_oe == !$past(i_second_pin_user_level))
      else $error("second pin od");
  second_pp_a:
    assert property (!i_first_pin_input_select && i_second_pin_pushpull_select |=>
      o_second_output_pin_oe && o_second_output_pin_out == $past(i_second_pin_user_level))
      else $error("second pin pp");
  second_power_good_a:
    assert property (i_first_pin_input_select && !i_power_good |=> o_second_output_pin_oe
      && !o_second_output_pin_out) else $error("second pin power_good");
  third_od_a:
    assert property (!i_core_rail_reset_enable && !i_third_seq_ctrl |=> !o_third_multi_pin_out
      && o_third_multi_pin_oe == !$past(i_third_pin_user_level)) else $error("third pin");
  restore_pulse_a:
    assert property (third_fall_s ##1 i_core_rail_reset_enable |-> ##1 o_core_restore_pulse
      ##1 !o_core_restore_pulse) else $error("restore pulse");
  restore_value_a:
    assert property (o_core_restore_pulse |-> o_core_buck_one_target == CORE_ONE_DEFAULT
      && o_core_buck_two_target == CORE_TWO_DEFAULT) else $error("restore value");
  ramp_step_a:
    assert property ($changed(o_core_buck_one_vsel) |-> o_core_buck_one_vsel ==
      W'($past(o_core_buck_one_vsel) + 1'b1) || o_core_buck_one_vsel ==
      W'($past(o_core_buck_one_vsel) - 1'b1)) else $error("ramp step");
endmodule : pmpcfg_properties

// ---- tb/pmpcfg_host.sv ----
/* Host side: memory reset request and core rail reset pull.
   Assumes pull-ups, so a released pin reads high. */
`timescale 1ns/100ps
module pmpcfg_host (
  input  wire logic i_mem,
  input  wire logic i_pull,
  input  wire logic i_oe1,
  input  wire logic i_out1,
  input  wire logic i_oe3,
  input  wire logic i_out3,
  output logic      o_pin1,
  output logic      o_pin3
);
  // wired-and: any low driver beats the pull-up
  assign o_pin1 = i_mem && !(i_oe1 && !i_out1);
  assign o_pin3 = !i_pull && !(i_oe3 && !i_out3);
endmodule : pmpcfg_host

// ---- tb/pmpcfg_top_test.sv ----
/* Self-checking bench for pmpcfg_top.
   Assumes package, design, checker and host model compiled first. */
`timescale 1ns/100ps
module pmpcfg_top_test;
  import pmpcfg_pkg::*;
  logic i_sys_clk = 0, i_reset_n = 0, i_first_pin_input_select = 0, i_first_pin_user_level = 1;
  logic i_second_pin_pushpull_select = 0, i_core_rail_reset_enable = 0, i_power_good = 1;
  logic i_memreset_latch_mode = 0, i_second_pin_user_level = 1, i_third_pin_user_level = 1;
  logic i_first_seq_ctrl = 0, i_first_seq_level = 0, i_third_seq_ctrl = 0, i_third_seq_level = 0;
  logic i_core_one_wr = 0, i_core_two_wr = 0, mem = 1, pull = 0, i_first_multi_pin_in;
  logic i_third_multi_pin_in, o_first_multi_pin_out, o_first_multi_pin_oe, o_core_restore_pulse;
  logic o_second_output_pin_out, o_second_output_pin_oe, o_third_multi_pin_out;
  logic o_third_multi_pin_oe;
  logic [5:0] i_core_one_wdata = 6'h05, i_core_two_wdata = 6'h07, o_core_buck_one_target;
  logic [5:0] o_core_buck_two_target, o_core_buck_one_vsel, o_core_buck_two_vsel;
  logic [7:0] i_slew_div = 8'h01;
  int mismatches = 0, total_checks = 0, pulses = 0;
  // {sel, pushpull, user1, user2, user3, power_good, mem, latch} then {oe1, oe2, out2, oe3}
  logic [11:0] rows [8] = '{12'h04d, 12'h3c0, 12'h6c4, 12'h7c6, 12'hee6, 12'hea4, 12'hbc4,
    12'hae0};
  wire [3:0] pins = {o_first_multi_pin_oe, o_second_output_pin_oe, o_second_output_pin_out,
    o_third_multi_pin_oe};
  pmpcfg_top dut (.*);
  pmpcfg_host host (.i_mem(mem), .i_pull(pull), .i_oe1(o_first_multi_pin_oe),
    .i_out1(o_first_multi_pin_out), .i_oe3(o_third_multi_pin_oe),
    .i_out3(o_third_multi_pin_out), .o_pin1(i_first_multi_pin_in),
    .o_pin3(i_third_multi_pin_in));
  initial forever #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_core_restore_pulse === 1'b1) pulses++;
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : wait_n
  initial begin
    wait_n(20);
    check({2'h0, pins}, 6'h00);
    i_reset_n = 1;
    foreach (rows[i]) begin
      {i_first_pin_input_select, i_second_pin_pushpull_select, i_first_pin_user_level,
        i_second_pin_user_level, i_third_pin_user_level, i_power_good, mem,
        i_memreset_latch_mode} = rows[i][11:4];
      wait_n(3);
      check({2'h0, pins}, {2'h0, rows[i][3:0]});
    end
    i_memreset_latch_mode = 1;
    wait_n(2);
    mem = 0;
    wait_n(3);
    check({2'h0, pins}, 6'h00);
    i_memreset_latch_mode = 0;
    wait_n(3);
    check({2'h0, pins}, 6'h04);
    {i_core_one_wr, i_core_two_wr} = 2'b11;
    wait_n(1);
    {i_core_one_wr, i_core_two_wr} = 2'b00;
    wait_n(30);
    check(o_core_buck_two_vsel, 6'h07);
    check(o_core_buck_one_vsel, 6'h05);
    // edge while disabled must give no restore pulse
    pull = 1;
    wait_n(4);
    pull = 0;
    i_core_rail_reset_enable = 1;
    wait_n(4);
    check(6'(pulses), 6'h00);
    pull = 1;
    wait_n(4);
    check(6'(pulses), 6'h01);
    check(o_core_buck_two_target, CORE_TWO_DEFAULT);
    check(o_core_buck_one_target, CORE_ONE_DEFAULT);
    wait_n(30);
    check(o_core_buck_two_vsel, CORE_TWO_DEFAULT);
    // reset with the third pin held low: release must not restore
    i_reset_n = 0;
    wait_n(2);
    i_reset_n = 1;
    wait_n(6);
    check(6'(pulses), 6'h01);
    stop_test;
  end
  initial begin
    #8000;
    mismatches++;
    stop_test;
  end
endmodule : pmpcfg_top_test
bind pmpcfg_top pmpcfg_properties #(.W(W)) chk (.*);
